// *** hdl/acsr_pkg.sv ***
// Purpose: Constants, types and helpers for the converter configuration and status registers.
// Assumes: 24-bit registers addressed by a 5-bit word address from the serial engine.
// Notes: Unimplemented bits are masked on write and read back as zero.
// Summary of operation
// - Any write to the delay register resets and restarts every active channel.
// - Bits 23-12 give channel 2 delay behind channel 1 in modulator periods.
// - Bits 11-0 give channel 0 delay behind channel 1 in modulator periods.
// - Amplifier codes 000-101 give gain 1 to 32; 110 and 111 act as gain 1.
// - Read increment: 11 whole map, 10 types, 01 groups, 00 fixed address.
// - Write increment 1 loops over writable registers; 0 keeps one address.
// - Idle data-ready pin floats when idle bit is 0, drives high when 1.
// - Merge bit gives one pulse timed by the last channel, else one per cycle in which any channel is ready.
// - Checksum format 0 is 16-bit; 1 is checksum then sixteen zeros.
// - Width code: 11 sign-extend 32, 10 zero-pad 32, 01 24-bit, 00 rounded 16.
// - Serial checksum enable appends a 16-bit checksum; host clocks the extra bits.
// - With map interrupt enabled, a map checksum error holds the ready pin low.
// - The held-low alert clears only when the lock key is written with the password.
// - With map interrupt disabled the checksum stays readable but never alerts.
// - Ready flags read 0 when ready, return to 1 only after a status read.
// - Offset correction enable adds no group delay.
// - Gain correction enable delays ready pulses by 24 modulator periods; sample words are not delayed.
// - Idle_tone_noise_level code 11 max, 10 medium, 01 minimum, 00 off.
// - Bias code 11 twice, 10 nominal, 01 two thirds, 00 half current.
// - Prescaler 00 undivided, 01 by 2, 10 by 4, 11 by 8.
package acsr_pkg;

   localparam logic [4:0] ADDR_DELAY = 5'h0A;
   localparam logic [4:0] ADDR_AMP = 5'h0B;
   localparam logic [4:0] ADDR_STATUS = 5'h0C;
   localparam logic [4:0] ADDR_CONFIG_A = 5'h0D;
   localparam logic [4:0] ADDR_MAP_LAST = 5'h1F;
   localparam logic [4:0] ADDR_WR_FIRST = 5'h08;
   localparam logic [4:0] ADDR_DATA_LAST = 5'h02;

   localparam logic [23:0] RST_DELAY = 24'h000000;
   localparam logic [23:0] RST_AMP = 24'h000000;
   localparam logic [23:0] RST_STATUS = 24'hA90000;
   localparam logic [23:0] RST_CONFIG_A = 24'h386050;
   localparam logic [2:0] RST_FLAGS = 3'h7;

   localparam logic [23:0] MASK_DELAY = 24'hFFFFFF;
   localparam logic [23:0] MASK_AMP = 24'h0001FF;
   localparam logic [23:0] MASK_STATUS = 24'hFFC000;
   localparam logic [23:0] MASK_CONFIG_A = 24'hFFE0FF;

   localparam int GAIN_CAL_TICKS = 24;
   localparam logic [1:0] READ_MAP = 2'h3;
   localparam logic [1:0] READ_TYPE = 2'h2;
   localparam logic [1:0] READ_GROUP = 2'h1;

   typedef struct packed {
      logic [11:0] ch2_delay_field;
      logic [11:0] ch0_delay_field;
      logic [8:0] input_amp_code;
      logic [1:0] read_inc;
      logic write_inc;
      logic ready_idle_float;
      logic ready_pulse_merge;
      logic crc_word_32;
      logic [1:0] data_width;
      logic serial_checksum_enable;
      logic map_int_enable;
      logic offset_corr_enable;
      logic scale_corr_enable;
      logic [1:0] idle_tone_noise_level;
      logic [1:0] bias_current_select;
      logic [1:0] prescale;
      logic [2:0] oversampling_ratio;
      logic [7:0] reference_trim;
   } acsr_cfg_t;

   // Gain as a power of two; the reserved codes fall back to unity gain.
   function automatic logic [2:0] gain_log2(input logic [2:0] code);
      gain_log2 = (code > 3'h5) ? 3'h0 : code;
   endfunction : gain_log2

   // Lowest and highest address of the loop that holds addr for a read mode.
   function automatic logic [9:0] read_bounds(input logic [4:0] addr, input logic [1:0] mode);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = 5'h00;
      hi = ADDR_MAP_LAST;
      if (mode == READ_TYPE) begin
         if (addr <= ADDR_DATA_LAST) begin
            hi = ADDR_DATA_LAST;
         end else begin
            lo = ADDR_WR_FIRST;
         end
      end else if (mode == READ_GROUP) begin
         if (addr <= 5'h01) begin
            hi = 5'h01;
         end else if (addr <= 5'h02) begin
            lo = 5'h02;
            hi = 5'h02;
         end else if (addr <= 5'h0B) begin
            lo = 5'h08;
            hi = 5'h0B;
         end else if (addr <= 5'h0E) begin
            lo = 5'h0C;
            hi = 5'h0E;
         end else if (addr <= 5'h10) begin
            lo = 5'h0F;
            hi = 5'h10;
         end else if (addr <= 5'h12) begin
            lo = 5'h11;
            hi = 5'h12;
         end else if (addr <= 5'h14) begin
            lo = 5'h13;
            hi = 5'h14;
         end else begin
            lo = ADDR_MAP_LAST;
         end
      end
      read_bounds = {lo, hi};
   endfunction : read_bounds

endpackage : acsr_pkg

// *** hdl/acsr_prescaler.sv ***
// Purpose: Derives the analog master clock enable from the master clock.
// Assumes: The divide code is a quasi-static register field.
// Notes: A code change restarts the count so no short period is produced.
`timescale 1ns/10ps
module acsr_prescaler #(
   parameter int CNT_W = 3
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Divide code and enable out
   input wire logic [1:0] prescale,
   output logic analog_master_clock_en
);
   initial begin
      if (CNT_W < 3) begin
         $error("acsr_prescaler: CNT_W must be at least 3");
      end
   end

   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [1:0] last_pre;
   logic next_en;
   logic [CNT_W-1:0] top;

   always_comb begin
      top = CNT_W'((1 << prescale) - 1);
      next_en = 1'b0;
      next_cnt = cnt + 1'b1;
      if (prescale != last_pre || cnt >= top) begin
         next_cnt = '0;
         next_en = (prescale == last_pre);
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= '0;
         last_pre <= 2'h0;
         analog_master_clock_en <= 1'b0;
      end else begin
         cnt <= next_cnt;
         last_pre <= prescale;
         analog_master_clock_en <= next_en;
      end
   end

   property p_undivided;
      @(posedge sys_clk) disable iff (sys_rst)
      (prescale == 2'h0 && last_pre == 2'h0) |=> analog_master_clock_en;
   endproperty
   a_undivided: assert property (p_undivided) else $error("undivided enable missing");

endmodule : acsr_prescaler

// *** hdl/acsr_regs.sv ***
// Purpose: Delay, amplifier, status and configuration registers with ready-pin control.
// Assumes: Ready events from the converters arrive on a modulator tick cycle.
// Notes: Addresses outside this bank read zero here; the serial engine muxes them.
`timescale 1ns/10ps
module acsr_regs #(
   parameter int GAIN_DELAY = acsr_pkg::GAIN_CAL_TICKS
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Register access from the serial engine
   input wire logic acc_start,
   input wire logic [4:0] acc_start_addr,
   input wire logic acc_write,
   input wire logic acc_read,
   input wire logic [23:0] acc_wdata,
   output logic [23:0] acc_rdata,
   output logic acc_rvalid,
   output logic [4:0] acc_addr,
   // Converter side
   input wire logic mod_tick,
   input wire logic [2:0] ch_active,
   input wire logic [2:0] ch_ready_raw,
   input wire logic [23:0] sample_in,
   output logic [31:0] sample_word,
   output logic [2:0] adc_restart,
   output logic [8:0] amp_gain_log2,
   output logic analog_master_clock_en,
   // Map checksum alert
   input wire logic map_crc_error,
   input wire logic lock_password_written,
   // Ready pin and configuration
   output logic data_ready_n_pin_out,
   output logic data_ready_n_pin_oe_n,
   output acsr_pkg::acsr_cfg_t cfg
);
   initial begin
      if (GAIN_DELAY < 1 || GAIN_DELAY > 64) begin
         $error("acsr_regs: GAIN_DELAY must lie in 1..64");
      end
   end

   logic [23:0] delay_reg, amp_reg, stat_reg, cfga_reg;
   logic [23:0] next_delay, next_amp, next_stat, next_cfga;
   logic [2:0] flags, next_flags;
   logic [4:0] next_addr;
   logic [23:0] next_rdata;
   logic next_rvalid;
   logic [2:0] next_restart;
   logic [8:0] next_gain;
   logic [31:0] next_word;
   logic [2:0] dline [GAIN_DELAY];
   logic [2:0] ev, seen, next_seen;
   logic crc_alert, next_alert, dr_pulse, next_pulse, fire;
   logic next_pin_out, next_pin_oe_n;
   logic [9:0] bnd;

   // Output formatting of one converter result.
   function automatic logic [31:0] fmt_word(input logic [23:0] s, input logic [1:0] mode);
      logic [15:0] r;
      r = (s[23:8] == 16'h7FFF) ? s[23:8] : s[23:8] + {15'h0000, s[7]};
      case (mode)
         2'h3: fmt_word = {{8{s[23]}}, s};
         2'h2: fmt_word = {s, 8'h00};
         2'h1: fmt_word = {8'h00, s};
         default: fmt_word = {16'h0000, r};
      endcase
   endfunction : fmt_word

   assign cfg.ch2_delay_field = delay_reg[23:12];
   assign cfg.ch0_delay_field = delay_reg[11:0];
   assign cfg.input_amp_code = amp_reg[8:0];
   assign cfg.read_inc = stat_reg[23:22];
   assign cfg.write_inc = stat_reg[21];
   assign cfg.ready_idle_float = stat_reg[20];
   assign cfg.ready_pulse_merge = stat_reg[19];
   assign cfg.crc_word_32 = stat_reg[18];
   assign cfg.data_width = stat_reg[17:16];
   assign cfg.serial_checksum_enable = stat_reg[15];
   assign cfg.map_int_enable = stat_reg[14];
   assign cfg.offset_corr_enable = cfga_reg[23];
   assign cfg.scale_corr_enable = cfga_reg[22];
   assign cfg.idle_tone_noise_level = cfga_reg[21:20];
   assign cfg.bias_current_select = cfga_reg[19:18];
   assign cfg.prescale = cfga_reg[17:16];
   assign cfg.oversampling_ratio = cfga_reg[15:13];
   assign cfg.reference_trim = cfga_reg[7:0];

   acsr_prescaler u_prescaler (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .prescale(cfga_reg[17:16]),
      .analog_master_clock_en(analog_master_clock_en)
   );

   // Register file, address counter and read port.
   always_comb begin
      next_delay = delay_reg;
      next_amp = amp_reg;
      next_stat = stat_reg;
      next_cfga = cfga_reg;
      next_restart = 3'h0;
      next_rvalid = acc_read;
      next_rdata = 24'h000000;
      next_addr = acc_addr;
      bnd = acsr_pkg::read_bounds(acc_addr, stat_reg[23:22]);
      if (acc_start) begin
         next_addr = acc_start_addr;
      end else if (acc_write) begin
         case (acc_addr)
            acsr_pkg::ADDR_DELAY: begin
               next_delay = acc_wdata & acsr_pkg::MASK_DELAY;
               next_restart = ch_active;
            end
            acsr_pkg::ADDR_AMP: next_amp = acc_wdata & acsr_pkg::MASK_AMP;
            acsr_pkg::ADDR_STATUS: next_stat = acc_wdata & acsr_pkg::MASK_STATUS;
            acsr_pkg::ADDR_CONFIG_A: next_cfga = acc_wdata & acsr_pkg::MASK_CONFIG_A;
            default: next_restart = 3'h0;
         endcase
         if (stat_reg[21]) begin
            next_addr = (acc_addr >= acsr_pkg::ADDR_MAP_LAST || acc_addr < acsr_pkg::ADDR_WR_FIRST)
               ? acsr_pkg::ADDR_WR_FIRST : acc_addr + 5'h01;
         end
      end else if (acc_read) begin
         case (acc_addr)
            acsr_pkg::ADDR_DELAY: next_rdata = delay_reg;
            acsr_pkg::ADDR_AMP: next_rdata = amp_reg;
            acsr_pkg::ADDR_STATUS: next_rdata = stat_reg | {21'h000000, flags};
            acsr_pkg::ADDR_CONFIG_A: next_rdata = cfga_reg;
            default: next_rdata = 24'h000000;
         endcase
         if (stat_reg[23:22] != 2'h0) begin
            next_addr = (acc_addr >= bnd[4:0]) ? bnd[9:5] : acc_addr + 5'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         delay_reg <= acsr_pkg::RST_DELAY;
         amp_reg <= acsr_pkg::RST_AMP;
         stat_reg <= acsr_pkg::RST_STATUS;
         cfga_reg <= acsr_pkg::RST_CONFIG_A;
         acc_addr <= 5'h00;
         acc_rdata <= 24'h000000;
         acc_rvalid <= 1'b0;
         adc_restart <= 3'h0;
      end else begin
         delay_reg <= next_delay;
         amp_reg <= next_amp;
         stat_reg <= next_stat;
         cfga_reg <= next_cfga;
         acc_addr <= next_addr;
         acc_rdata <= next_rdata;
         acc_rvalid <= next_rvalid;
         adc_restart <= next_restart;
      end
   end

   // Decoded gains and formatted result.
   always_comb begin
      next_gain = {acsr_pkg::gain_log2(amp_reg[8:6]), acsr_pkg::gain_log2(amp_reg[5:3]),
                   acsr_pkg::gain_log2(amp_reg[2:0])};
      next_word = fmt_word(sample_in, stat_reg[17:16]);
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         amp_gain_log2 <= 9'h000;
         sample_word <= 32'h00000000;
      end else begin
         amp_gain_log2 <= next_gain;
         sample_word <= next_word;
      end
   end

   // Gain correction delay line, advanced once per modulator period.
   // Only events taken while correction is on enter it, so enabling correction never
   // reports again a result that already went straight to the pin.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < GAIN_DELAY; i++) begin
            dline[i] <= 3'h0;
         end
      end else if (mod_tick) begin
         dline[0] <= ch_ready_raw & {3{cfga_reg[22]}};
         for (int i = 1; i < GAIN_DELAY; i++) begin
            dline[i] <= dline[i-1];
         end
      end
   end

   // Ready events, flags, merge, alert and pin.
   always_comb begin
      ev = cfga_reg[22] ? (dline[GAIN_DELAY-1] & {3{mod_tick}}) : ch_ready_raw;
      next_seen = seen | ev;
      fire = 1'b0;
      if (stat_reg[19]) begin
         if (ch_active != 3'h0 && (next_seen & ch_active) == ch_active) begin
            fire = 1'b1;
            next_seen = 3'h0;
         end
      end else begin
         fire = (ev != 3'h0);
         next_seen = 3'h0;
      end
      next_flags = flags;
      if (acc_read && !acc_start && acc_addr == acsr_pkg::ADDR_STATUS) begin
         next_flags = 3'h7;
      end
      // A new result in the same cycle as the status read keeps its ready indication.
      next_flags = next_flags & ~ev;
      next_pulse = fire ? 1'b1 : (mod_tick ? 1'b0 : dr_pulse);
      next_alert = crc_alert;
      if (map_crc_error && stat_reg[14]) begin
         next_alert = 1'b1;
      end else if (lock_password_written) begin
         next_alert = 1'b0;
      end
      if (next_alert || next_pulse) begin
         next_pin_out = 1'b0;
         next_pin_oe_n = 1'b0;
      end else begin
         next_pin_out = 1'b1;
         next_pin_oe_n = !stat_reg[20];
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags <= acsr_pkg::RST_FLAGS;
         seen <= 3'h0;
         dr_pulse <= 1'b0;
         crc_alert <= 1'b0;
         data_ready_n_pin_out <= 1'b1;
         data_ready_n_pin_oe_n <= 1'b1;
      end else begin
         flags <= next_flags;
         seen <= next_seen;
         dr_pulse <= next_pulse;
         crc_alert <= next_alert;
         data_ready_n_pin_out <= next_pin_out;
         data_ready_n_pin_oe_n <= next_pin_oe_n;
      end
   end

   property p_restart;
      @(posedge sys_clk) disable iff (sys_rst)
      (acc_write && !acc_start && acc_addr == acsr_pkg::ADDR_DELAY) |=>
         adc_restart == $past(ch_active);
   endproperty
   a_restart: assert property (p_restart) else $error("restart not issued");

   property p_alert_hold;
      @(posedge sys_clk) disable iff (sys_rst)
      (crc_alert && !lock_password_written) |=>
         crc_alert ##0 (!data_ready_n_pin_out && !data_ready_n_pin_oe_n);
   endproperty
   a_alert_hold: assert property (p_alert_hold) else $error("alert not held low");

   property p_alert_clear;
      @(posedge sys_clk) disable iff (sys_rst)
      (lock_password_written && !(map_crc_error && stat_reg[14])) |=> !crc_alert;
   endproperty
   a_alert_clear: assert property (p_alert_clear) else $error("alert not cleared");

   property p_no_alert;
      @(posedge sys_clk) disable iff (sys_rst)
      (!stat_reg[14] && !crc_alert) |=> !crc_alert;
   endproperty
   a_no_alert: assert property (p_no_alert) else $error("alert while disabled");

   property p_flag_read;
      @(posedge sys_clk) disable iff (sys_rst)
      (acc_read && !acc_start && acc_addr == acsr_pkg::ADDR_STATUS && ev == 3'h0) |=>
         flags == 3'h7;
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flags not restored");

   property p_gain;
      @(posedge sys_clk) disable iff (sys_rst)
      $stable(amp_reg) |-> amp_gain_log2[2:0] == ((amp_reg[2:0] > 3'h5) ? 3'h0 : amp_reg[2:0]);
   endproperty
   a_gain: assert property (p_gain) else $error("gain decode wrong");

   property p_write_fixed;
      @(posedge sys_clk) disable iff (sys_rst)
      (acc_write && !acc_start && !stat_reg[21]) |=> $stable(acc_addr);
   endproperty
   a_write_fixed: assert property (p_write_fixed) else $error("write address moved");

   property p_amp_zero;
      @(posedge sys_clk) disable iff (sys_rst)
      (acc_read && !acc_start && acc_addr == acsr_pkg::ADDR_AMP) |=>
         acc_rvalid && acc_rdata[23:9] == 15'h0000;
   endproperty
   a_amp_zero: assert property (p_amp_zero) else $error("unimplemented bits set");

endmodule : acsr_regs

// *** tb/acsr_host_model.sv ***
// Purpose: Host side of the register port, issuing start, write and read strobes.
// Assumes: The device takes one strobe per rising edge of sys_clk.
// Notes: A gap of idle cycles models a slow host; the data bus is scrambled when idle.
`timescale 1ns/10ps
module acsr_host_model (
   // Clock
   input wire logic sys_clk,
   // Requests to the device
   output logic acc_start,
   output logic [4:0] acc_start_addr,
   output logic acc_write,
   output logic acc_read,
   output logic [23:0] acc_wdata,
   // Answers from the device
   input wire logic [23:0] acc_rdata,
   input wire logic acc_rvalid
);
   int gap = 0;
   logic [4:0] cur = 5'h00;

   initial begin
      acc_start = 1'b0;
      acc_start_addr = 5'h15;
      acc_write = 1'b0;
      acc_read = 1'b0;
      acc_wdata = 24'h5A5A5A;
   end

   task automatic lead();
      repeat (gap + 1) @(posedge sys_clk);
      #1;
   endtask : lead

   task automatic start(input logic [4:0] a);
      lead();
      acc_start = 1'b1;
      acc_start_addr = a;
      cur = a;
      @(posedge sys_clk);
      #1 acc_start = 1'b0;
      acc_start_addr = ~a;
   endtask : start

   task automatic write(input logic [23:0] d);
      logic [23:0] v;
      v = d;
      if (cur == acsr_pkg::ADDR_STATUS) v[13:12] = 2'h0;
      lead();
      acc_write = 1'b1;
      acc_wdata = v;
      cur = cur + 5'h01;
      @(posedge sys_clk);
      #1 acc_write = 1'b0;
      acc_wdata = ~v;
   endtask : write

   // The answer is taken only while the device flags it valid.
   task automatic read(output logic [23:0] d);
      lead();
      acc_read = 1'b1;
      @(posedge sys_clk);
      #1 acc_read = 1'b0;
      d = (acc_rvalid === 1'b1) ? acc_rdata : 24'hXXXXXX;
   endtask : read

   task automatic write_reg(input logic [4:0] a, input logic [23:0] d);
      start(a);
      write(d);
   endtask : write_reg
endmodule : acsr_host_model

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the configuration and status register bank.
// Assumes: Modulator ticks every fourth cycle; ready events land on tick cycles.
// Notes: The gain correction delay is shortened to keep the run brief.
`timescale 1ns/10ps
module tb_top;
   localparam int GD = 4;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic acc_start, acc_write, acc_read, acc_rvalid, analog_master_clock_en;
   logic [4:0] acc_start_addr, acc_addr;
   logic [23:0] acc_wdata, acc_rdata, rd, s;
   logic mod_tick = 1'b0;
   logic [1:0] tcnt = 2'h0;
   logic [2:0] ch_active = 3'h0;
   logic [2:0] ch_ready_raw = 3'h0;
   logic [2:0] adc_restart;
   logic [23:0] sample_in = 24'h000000;
   logic [31:0] sample_word, m;
   logic [8:0] amp_gain_log2, g;
   logic map_crc_error = 1'b0;
   logic lock_password_written = 1'b0;
   logic data_ready_n_pin_out, data_ready_n_pin_oe_n;
   acsr_pkg::acsr_cfg_t cfg;
   logic [23:0] d [4];
   logic [23:0] msk [4] = '{24'hFFFFFF, 24'h0001FF, 24'hFFC000, 24'hFFE0FF};
   logic [23:0] rstv [4] = '{24'h000000, 24'h000000, 24'hA90007, 24'h386050};
   logic [1:0] tm [9] = '{2'h3, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h2};
   logic [4:0] ta [9] = '{5'h1F, 5'h02, 5'h1F, 5'h0B, 5'h0E, 5'h01, 5'h0C, 5'h1F, 5'h0A};
   logic [4:0] tn [9] = '{5'h00, 5'h00, 5'h08, 5'h08, 5'h0C, 5'h00, 5'h0C, 5'h08, 5'h0A};
   int num_errors = 0;
   int num_checks = 0;
   int seed = 860;
   int cycles = 0;
   int n;

   acsr_regs #(.GAIN_DELAY(GD)) u_acsr_regs (.sys_clk, .sys_rst, .acc_start, .acc_start_addr,
      .acc_write, .acc_read, .acc_wdata, .acc_rdata, .acc_rvalid, .acc_addr, .mod_tick,
      .ch_active, .ch_ready_raw, .sample_in, .sample_word, .adc_restart, .amp_gain_log2,
      .analog_master_clock_en, .map_crc_error, .lock_password_written, .data_ready_n_pin_out,
      .data_ready_n_pin_oe_n, .cfg);
   acsr_host_model u_host (.sys_clk, .acc_start, .acc_start_addr, .acc_write, .acc_read,
      .acc_wdata, .acc_rdata, .acc_rvalid);

   always #4 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      #1;
      tcnt = tcnt + 2'h1;
      mod_tick = (tcnt == 2'h0);
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   function automatic logic [23:0] st(input logic [1:0] ri, input logic wi, input logic fl,
      input logic mg, input logic [1:0] w, input logic ie);
      st = {ri, wi, fl, mg, 1'b0, w, 1'b0, ie, 14'h0000};
   endfunction : st

   function automatic logic [2:0] glog(input logic [2:0] c);
      glog = (c > 3'h5) ? 3'h0 : c;
   endfunction : glog

   // Rounded 16-bit form saturates at the largest positive code.
   function automatic logic [31:0] fmt(input logic [1:0] w, input logic [23:0] v);
      logic [16:0] r;
      r = {1'b0, v[23:8]} + {16'h0000, v[7]};
      case (w)
         2'h3: fmt = {{8{v[23]}}, v};
         2'h2: fmt = {v, 8'h00};
         2'h1: fmt = {8'h00, v};
         default: fmt = {16'h0000, (v[23:8] == 16'h7FFF && v[7]) ? 16'h7FFF : r[15:0]};
      endcase
   endfunction : fmt

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic set_status(input logic [23:0] v);
      u_host.write_reg(acsr_pkg::ADDR_STATUS, v);
   endtask : set_status

   task automatic pulse_ready(input logic [2:0] c);
      @(posedge sys_clk);
      while (tcnt !== 2'h3) @(posedge sys_clk);
      #1 ch_ready_raw = c;
      cyc(1);
      ch_ready_raw = 3'h0;
   endtask : pulse_ready

   task automatic strobe(input logic e, input logic l);
      cyc(1);
      map_crc_error = e;
      lock_password_written = l;
      cyc(1);
      map_crc_error = 1'b0;
      lock_password_written = 1'b0;
   endtask : strobe

   initial begin
      repeat (5) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      chk(data_ready_n_pin_oe_n, 1'b1);
      u_host.start(acsr_pkg::ADDR_DELAY);
      for (int j = 0; j < 4; j++) begin
         u_host.read(rd);
         chk(rd, rstv[j]);
      end
      for (int i = 0; i < 8; i++) begin
         u_host.gap = $unsigned($random(seed)) % 3;
         for (int j = 0; j < 4; j++) d[j] = (i == 0) ? 24'hFFFFFF : 24'($random(seed));
         d[2] = {3'h5, d[2][20:15], 1'b0, 14'h0000};
         ch_active = 3'($random(seed));
         u_host.write_reg(acsr_pkg::ADDR_DELAY, d[0]);
         chk(adc_restart, ch_active);
         cyc(1);
         chk(adc_restart, 3'h0);
         u_host.start(acsr_pkg::ADDR_AMP);
         for (int j = 1; j < 4; j++) u_host.write(d[j]);
         chk(acc_addr, 5'h0E);
         u_host.start(acsr_pkg::ADDR_DELAY);
         for (int j = 0; j < 4; j++) begin
            u_host.read(rd);
            chk(rd, (d[j] & msk[j]) | ((j == 2) ? 24'h000007 : 24'h000000));
         end
         chk({cfg.ch2_delay_field, cfg.ch0_delay_field}, d[0]);
         chk({cfg.ready_idle_float, cfg.ready_pulse_merge, cfg.crc_word_32, cfg.data_width,
            cfg.serial_checksum_enable}, d[2][20:15]);
         chk({cfg.offset_corr_enable, cfg.scale_corr_enable, cfg.idle_tone_noise_level,
            cfg.bias_current_select, cfg.prescale, cfg.oversampling_ratio, cfg.reference_trim},
            {d[3][23:13], d[3][7:0]});
      end
      u_host.gap = 0;
      u_host.write_reg(acsr_pkg::ADDR_CONFIG_A, 24'h386050);
      for (int c = 0; c < 8; c++) begin
         g = {3'(c + 2), 3'(c + 1), 3'(c)};
         u_host.write_reg(acsr_pkg::ADDR_AMP, {15'h0000, g});
         cyc(2);
         chk(amp_gain_log2, {glog(g[8:6]), glog(g[5:3]), glog(g[2:0])});
      end
      for (int i = 0; i < 9; i++) begin
         set_status(st(tm[i], i != 8, 1'b0, 1'b1, 2'h1, 1'b0));
         u_host.start(ta[i]);
         if (i < 7) begin
            u_host.read(rd);
            if (ta[i] < 5'h0A || ta[i] > 5'h0D) chk(rd, 24'h000000);
         end else begin
            u_host.write(24'h000123);
         end
         chk(acc_addr, tn[i]);
      end
      for (int w = 0; w < 4; w++) begin
         set_status(st(2'h2, 1'b1, 1'b0, 1'b1, 2'(w), 1'b0));
         for (int k = 0; k < 4; k++) begin
            s = (k == 0) ? 24'h7FFFFF : (k == 1) ? 24'h800080 : 24'($random(seed));
            cyc(1);
            sample_in = s;
            cyc(2);
            m = (w == 0) ? 32'h0000FFFF : (w == 1) ? 32'h00FFFFFF : 32'hFFFFFFFF;
            chk(sample_word & m, fmt(2'(w), s) & m);
         end
      end
      ch_active = 3'h7;
      set_status(st(2'h2, 1'b1, 1'b0, 1'b0, 2'h1, 1'b0));
      pulse_ready(3'h1);
      chk({data_ready_n_pin_out, data_ready_n_pin_oe_n}, 2'h0);
      cyc(6);
      chk(data_ready_n_pin_oe_n, 1'b1);
      for (int k = 0; k < 2; k++) begin
         u_host.start(acsr_pkg::ADDR_STATUS);
         u_host.read(rd);
         chk(rd[2:0], (k == 0) ? 3'h6 : 3'h7);
      end
      set_status(st(2'h2, 1'b1, 1'b1, 1'b1, 2'h1, 1'b0));
      cyc(1);
      chk({data_ready_n_pin_out, data_ready_n_pin_oe_n}, 2'h2);
      pulse_ready(3'h1);
      pulse_ready(3'h2);
      chk(data_ready_n_pin_out, 1'b1);
      pulse_ready(3'h4);
      chk(data_ready_n_pin_out, 1'b0);
      set_status(st(2'h2, 1'b1, 1'b1, 1'b0, 2'h1, 1'b0));
      u_host.write_reg(acsr_pkg::ADDR_CONFIG_A, 24'h786050);
      cyc(8);
      pulse_ready(3'h2);
      n = 1;
      while (data_ready_n_pin_out !== 1'b0 && n < 60) begin
         cyc(1);
         n++;
      end
      chk(n, 4 * GD + 1);
      cyc(8);
      set_status(st(2'h2, 1'b1, 1'b1, 1'b0, 2'h1, 1'b1));
      strobe(1'b1, 1'b0);
      cyc(20);
      chk({data_ready_n_pin_out, data_ready_n_pin_oe_n}, 2'h0);
      strobe(1'b0, 1'b1);
      cyc(6);
      chk({data_ready_n_pin_out, data_ready_n_pin_oe_n}, 2'h2);
      set_status(st(2'h2, 1'b1, 1'b1, 1'b0, 2'h1, 1'b0));
      strobe(1'b1, 1'b0);
      cyc(6);
      chk({data_ready_n_pin_out, data_ready_n_pin_oe_n}, 2'h2);
      for (int p = 0; p < 4; p++) begin
         u_host.write_reg(acsr_pkg::ADDR_CONFIG_A, 24'h386050 | (24'(p) << 16));
         cyc(16);
         n = 0;
         repeat (32) begin
            cyc(1);
            if (analog_master_clock_en === 1'b1) n++;
         end
         chk(n, 32 >> p);
      end
      final_report();
   end
endmodule : tb_top
